// file: logic/lbd_pkg.sv
// package of constants for the local bus dma configuration block
// How it works
// - With the second decode select bit at zero the first peripheral decoding applies and the second irq input is active high, at one the alternate decoding applies and it is active low.
// - A dma request drops in the internal view only after the programmed validation delay, with 000 meaning no delay and 100 reserved.
// - Both dma requests are validated over 8, 16 or 32 falling edges of the local bus out clock for settings 101, 110 and 111.
// - A request still inactive after the validation delay marks end of packet for the current transfer.
// - With interrupt pass at zero the data mode state machine interprets every peripheral interrupt itself.
// - With interrupt pass at one interrupts of the third and fourth framer status registers are forwarded to the interrupt queue instead.
// - The config block base is fetched from the host word at the indirect address register, whose two low bits are zero.
// - The transmit interrupt queue starts at the dword aligned transmit base address.
// - The transmit queue holds (n+1) times 16 dwords for the 8-bit length n, up to 4096.
// - The receive interrupt queue starts at the dword aligned receive base address.
// - The receive queue holds (n+1) times 16 dwords for the 8-bit length n, up to 4096.
// - The bytes of the peripheral pointer registers are the register addresses driven on the local bus.
// - With separate irq pins at zero input a serves both channels and input b is ignored, at one each channel has its own input.
package lbd_pkg;
    localparam logic [7:0] OFF_CCBA     = 8'h44;
    localparam logic [7:0] OFF_TRAN     = 8'h4c;
    localparam logic [7:0] OFF_TIQBA    = 8'h50;
    localparam logic [7:0] OFF_TIQL     = 8'h54;
    localparam logic [7:0] OFF_RIQBA    = 8'h58;
    localparam logic [7:0] OFF_RIQL     = 8'h5c;
    localparam logic [7:0] OFF_PTR0     = 8'h60;
    localparam logic [7:0] OFF_PTR1     = 8'h64;
    localparam logic [7:0] OFF_CONF     = 8'h40;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h78;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h7c;
    localparam logic [31:0] RST_ZERO    = 32'h0000_0000;
    localparam logic [31:0] RST_TRAN    = 32'h0000_0003;
    localparam logic [31:0] RST_CONF    = 32'h0000_0000;
    localparam logic [31:0] ALIGN_MASK  = 32'hffff_fffc;
    // conf register fields
    localparam int CONF_DECODE2  = 0;
    localparam int CONF_SPINPINS = 1;
    localparam int CONF_IPASS    = 2;
    localparam int CONF_DV_LO    = 4;
    localparam int CONF_EBC_RSTN = 8;
    localparam int CONF_LBU_RSTN = 9;
    localparam logic [2:0] DV_NONE = 3'h0;
    localparam logic [2:0] DV_RSVD = 3'h4;
    localparam logic [2:0] DV_8    = 3'h5;
    localparam logic [2:0] DV_16   = 3'h6;
    localparam logic [2:0] DV_32   = 3'h7;
    localparam logic [5:0] CNT_8   = 6'h08;
    localparam logic [5:0] CNT_16  = 6'h10;
    localparam logic [5:0] CNT_32  = 6'h20;
    localparam logic [13:0] QUEUE_UNIT = 14'h0010;
    // irq status bits
    localparam int ST_EOP_A = 0;
    localparam int ST_EOP_B = 1;
    localparam int ST_PASS  = 2;
    localparam int ST_ERR   = 3;
    // cause codes of the interrupt source
    localparam logic [1:0] SRC_FRAMER3 = 2'h2;
    localparam logic [1:0] SRC_FRAMER4 = 2'h3;
endpackage : lbd_pkg

// file: logic/lbd_top.sv
// local bus dma configuration block with axi4-lite register slave
`timescale 1ns/1ps
module lbd_top (
    input  wire logic        clk_sys_in,
    input  wire logic        srst_in,
    input  wire logic [7:0]  s_awaddr_in,
    input  wire logic        s_awvalid_in,
    output logic             s_awready_out,
    input  wire logic [31:0] s_wdata_in,
    input  wire logic [3:0]  s_wstrb_in,
    input  wire logic        s_wvalid_in,
    output logic             s_wready_out,
    output logic [1:0]       s_bresp_out,
    output logic             s_bvalid_out,
    input  wire logic        s_bready_in,
    input  wire logic [7:0]  s_araddr_in,
    input  wire logic        s_arvalid_in,
    output logic             s_arready_out,
    output logic [31:0]      s_rdata_out,
    output logic [1:0]       s_rresp_out,
    output logic             s_rvalid_out,
    input  wire logic        s_rready_in,
    input  wire logic        local_bus_out_clock_in,
    input  wire logic        dma_request_chan_a_in,
    input  wire logic        dma_request_chan_b_in,
    input  wire logic        peripheral_irq_in_a_in,
    input  wire logic        peripheral_irq_in_b_in,
    input  wire logic [1:0]  irq_source_in,
    input  wire logic [31:0] host_rdata_in,
    input  wire logic        host_rvalid_in,
    input  wire logic        fetch_start_in,
    output logic             host_rd_req_out,
    output logic [31:0]      host_rd_addr_out,
    output logic [31:0]      ccb_base_out,
    output logic [31:0]      txq_base_out,
    output logic [12:0]      txq_dwords_out,
    output logic [31:0]      rxq_base_out,
    output logic [12:0]      rxq_dwords_out,
    output logic [63:0]      periph_reg_addr_out,
    output logic [1:0]       dma_req_valid_out,
    output logic [1:0]       eop_pulse_out,
    output logic             decode_alt_out,
    output logic [1:0]       chan_irq_out,
    output logic             data_mode_state_machine_irq_out,
    output logic             queue_irq_out,
    output logic             ext_bus_ctrl_reset_n_out,
    output logic             local_bus_unit_reset_n_out,
    output logic             irq_out
);
    import lbd_pkg::*;
    // every check below belongs to the system clock domain
    default clocking cb_sys @(posedge clk_sys_in);
    endclocking
    default disable iff (srst_in);

    // ************************************************
    // register bus
    // ************************************************
    logic [31:0] ccba_q, tran_q, tiqba_q, tiql_q, riqba_q, riql_q;
    logic [31:0] ptr0_q, ptr1_q, conf_q, stat_q, mask_q;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        aw_have_q, w_have_q, bvalid_q, rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  bresp_q, rresp_q;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    function automatic logic known(input logic [7:0] a);
        return (a == OFF_CCBA) || (a == OFF_TRAN) || (a == OFF_TIQBA) ||
               (a == OFF_TIQL) || (a == OFF_RIQBA) || (a == OFF_RIQL) ||
               (a == OFF_PTR0) || (a == OFF_PTR1) || (a == OFF_CONF) ||
               (a == OFF_IRQ_STAT) || (a == OFF_IRQ_MASK);
    endfunction : known

    wire do_write = aw_have_q && w_have_q && !bvalid_q;
    wire [31:0] wval = merge(32'h0, wdata_q, wstrb_q);
    assign s_awready_out = !aw_have_q && !bvalid_q;
    assign s_wready_out  = !w_have_q && !bvalid_q;
    assign s_arready_out = !rvalid_q;
    assign s_bvalid_out  = bvalid_q;
    assign s_bresp_out   = bresp_q;
    assign s_rvalid_out  = rvalid_q;
    assign s_rdata_out   = rdata_q;
    assign s_rresp_out   = rresp_q;

    wire wr_ccba  = do_write && awaddr_q == OFF_CCBA;
    wire wr_tran  = do_write && awaddr_q == OFF_TRAN;
    wire wr_tiqba = do_write && awaddr_q == OFF_TIQBA;
    wire wr_tiql  = do_write && awaddr_q == OFF_TIQL;
    wire wr_riqba = do_write && awaddr_q == OFF_RIQBA;
    wire wr_riql  = do_write && awaddr_q == OFF_RIQL;
    wire wr_ptr0  = do_write && awaddr_q == OFF_PTR0;
    wire wr_ptr1  = do_write && awaddr_q == OFF_PTR1;
    wire wr_conf  = do_write && awaddr_q == OFF_CONF;
    wire wr_stat  = do_write && awaddr_q == OFF_IRQ_STAT;
    wire wr_mask  = do_write && awaddr_q == OFF_IRQ_MASK;

    wire [31:0] rd_mux =
        (s_araddr_in == OFF_CCBA)     ? ccba_q  :
        (s_araddr_in == OFF_TRAN)     ? tran_q  :
        (s_araddr_in == OFF_TIQBA)    ? tiqba_q :
        (s_araddr_in == OFF_TIQL)     ? tiql_q  :
        (s_araddr_in == OFF_RIQBA)    ? riqba_q :
        (s_araddr_in == OFF_RIQL)     ? riql_q  :
        (s_araddr_in == OFF_PTR0)     ? ptr0_q  :
        (s_araddr_in == OFF_PTR1)     ? ptr1_q  :
        (s_araddr_in == OFF_CONF)     ? conf_q  :
        (s_araddr_in == OFF_IRQ_STAT) ? stat_q  :
        (s_araddr_in == OFF_IRQ_MASK) ? mask_q  : RST_ZERO;

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= 2'h0;
            awaddr_q  <= 8'h00;
            wdata_q   <= RST_ZERO;
            wstrb_q   <= 4'h0;
        end else begin
            if (s_awvalid_in && s_awready_out) begin
                aw_have_q <= 1'b1;
                awaddr_q  <= s_awaddr_in;
            end
            if (s_wvalid_in && s_wready_out) begin
                w_have_q <= 1'b1;
                wdata_q  <= s_wdata_in;
                wstrb_q  <= s_wstrb_in;
            end
            if (do_write) begin
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= known(awaddr_q) ? 2'h0 : 2'h2;
            end else if (bvalid_q && s_bready_in) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            rvalid_q <= 1'b0;
            rdata_q  <= RST_ZERO;
            rresp_q  <= 2'h0;
        end else if (s_arvalid_in && s_arready_out) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_mux;
            rresp_q  <= known(s_araddr_in) ? 2'h0 : 2'h2;
        end else if (rvalid_q && s_rready_in) begin
            rvalid_q <= 1'b0;
        end
    end

    // ************************************************
    // configuration registers
    // ************************************************
    // merged words; bases drop their low bits and lengths keep one byte
    wire [31:0] ccba_m  = merge(ccba_q, wdata_q, wstrb_q);
    wire [31:0] tiqba_m = merge(tiqba_q, wdata_q, wstrb_q);
    wire [31:0] tiql_m  = merge(tiql_q, wdata_q, wstrb_q);
    wire [31:0] riqba_m = merge(riqba_q, wdata_q, wstrb_q);
    wire [31:0] riql_m  = merge(riql_q, wdata_q, wstrb_q);
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            ccba_q  <= RST_ZERO;
            tran_q  <= RST_TRAN;
            tiqba_q <= RST_ZERO;
            tiql_q  <= RST_ZERO;
            riqba_q <= RST_ZERO;
            riql_q  <= RST_ZERO;
            ptr0_q  <= RST_ZERO;
            ptr1_q  <= RST_ZERO;
            conf_q  <= RST_CONF;
            mask_q  <= RST_ZERO;
        end else begin
            if (wr_ccba)  ccba_q  <= ccba_m & ALIGN_MASK;
            if (wr_tran)  tran_q  <= merge(tran_q, wdata_q, wstrb_q);
            if (wr_tiqba) tiqba_q <= tiqba_m & ALIGN_MASK;
            if (wr_tiql)  tiql_q  <= {24'h0, tiql_m[7:0]};
            if (wr_riqba) riqba_q <= riqba_m & ALIGN_MASK;
            if (wr_riql)  riql_q  <= {24'h0, riql_m[7:0]};
            if (wr_ptr0)  ptr0_q  <= merge(ptr0_q, wdata_q, wstrb_q);
            if (wr_ptr1)  ptr1_q  <= merge(ptr1_q, wdata_q, wstrb_q);
            if (wr_conf)  conf_q  <= merge(conf_q, wdata_q, wstrb_q);
            if (wr_mask)  mask_q  <= merge(mask_q, wdata_q, wstrb_q);
        end
    end

    wire [2:0] dv_sel = conf_q[CONF_DV_LO +: 3];
    wire       ipass  = conf_q[CONF_IPASS];
    // unit resets follow the software bits
    assign ext_bus_ctrl_reset_n_out   = conf_q[CONF_EBC_RSTN];
    assign local_bus_unit_reset_n_out = conf_q[CONF_LBU_RSTN];
    wire lbu_run = conf_q[CONF_LBU_RSTN];

    assign txq_dwords_out = ({5'h0, tiql_q[7:0]} + 13'h1) * QUEUE_UNIT[12:0];
    assign rxq_dwords_out = ({5'h0, riql_q[7:0]} + 13'h1) * QUEUE_UNIT[12:0];
    assign txq_base_out = tiqba_q;
    assign rxq_base_out = riqba_q;
    // pointer bytes drive local bus addresses
    assign periph_reg_addr_out = {ptr1_q, ptr0_q};

    // ************************************************
    // indirect block fetch
    // ************************************************
    logic        fetch_busy_q;
    logic [31:0] ccb_q;
    assign host_rd_req_out  = fetch_busy_q;
    assign host_rd_addr_out = ccba_q;
    assign ccb_base_out     = ccb_q;
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            fetch_busy_q <= 1'b0;
            ccb_q        <= RST_ZERO;
        end else if (fetch_busy_q && host_rvalid_in) begin
            fetch_busy_q <= 1'b0;
            ccb_q        <= host_rdata_in;
        end else if (fetch_start_in && lbu_run) begin
            fetch_busy_q <= 1'b1;
        end
    end

    // ************************************************
    // dma request validation
    // ************************************************
    logic       lclk_q;
    // the out clock must stay well below half the system rate, or falls
    // between two samples are lost
    logic [1:0] valid_q, eop_q;
    logic [5:0] cnt_q [2];
    // falling edge of out clock, sampled in system domain
    wire lclk_fall = lclk_q && !local_bus_out_clock_in;
    wire [1:0] req_raw = {dma_request_chan_b_in, dma_request_chan_a_in};
    wire [5:0] limit = (dv_sel == DV_8)  ? CNT_8  :
                       (dv_sel == DV_16) ? CNT_16 :
                       (dv_sel == DV_32) ? CNT_32 : 6'h00;
    // reserved setting treated as no delay
    wire no_delay = (dv_sel == DV_NONE) || (dv_sel == DV_RSVD) ||
                    (limit == 6'h00);
    assign dma_req_valid_out = valid_q;
    assign eop_pulse_out     = eop_q;

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            lclk_q <= 1'b0;
        end else begin
            lclk_q <= local_bus_out_clock_in;
        end
    end

    for (genvar c = 0; c < 2; c++) begin : g_req
        always_ff @(posedge clk_sys_in) begin
            if (srst_in || !lbu_run) begin
                valid_q[c] <= 1'b0;
                eop_q[c]   <= 1'b0;
                cnt_q[c]   <= 6'h00;
            end else begin
                eop_q[c] <= 1'b0;
                if (lclk_fall) begin
                    if (req_raw[c]) begin
                        valid_q[c] <= 1'b1;
                        cnt_q[c]   <= 6'h00;
                    end else if (valid_q[c]) begin
                        if (no_delay || cnt_q[c] + 6'h01 >= limit) begin
                            valid_q[c] <= 1'b0;
                            eop_q[c]   <= 1'b1;
                        end else begin
                            cnt_q[c] <= cnt_q[c] + 6'h01;
                        end
                    end
                end
            end
        end
    end

    // ************************************************
    // peripheral interrupt routing
    // ************************************************
    // alternate decoding inverts input b
    assign decode_alt_out = conf_q[CONF_DECODE2];
    wire irq_b_act = peripheral_irq_in_b_in ^ conf_q[CONF_DECODE2];
    wire irq_a_act = peripheral_irq_in_a_in;
    assign chan_irq_out = conf_q[CONF_SPINPINS] ? {irq_b_act, irq_a_act}
                                                : {irq_a_act, irq_a_act};
    wire any_irq  = irq_a_act || (conf_q[CONF_SPINPINS] && irq_b_act);
    wire framer34 = (irq_source_in == SRC_FRAMER3) ||
                    (irq_source_in == SRC_FRAMER4);
    assign queue_irq_out = lbu_run && any_irq && ipass && framer34;
    assign data_mode_state_machine_irq_out  = lbu_run && any_irq && !(ipass && framer34);

    // ************************************************
    // interrupt status
    // ************************************************
    wire [31:0] ev = {28'h0, (dv_sel == DV_RSVD), queue_irq_out,
                      eop_q[1], eop_q[0]};
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            stat_q <= RST_ZERO;
        end else begin
            // set wins over write-one clear
            stat_q <= (stat_q & ~(wr_stat ? wval : 32'h0)) | ev;
        end
    end
    assign irq_out = |(stat_q & mask_q);

    // ************************************************
    // checks
    // ************************************************
    sequence s_req_drop(c);
        lclk_fall && !req_raw[c] && valid_q[c];
    endsequence
    a_eop_nodelay: assert property (
        (s_req_drop(0) and no_delay && lbu_run) |=> eop_q[0] && !valid_q[0])
        else $error("eop missing");
    a_hold_valid: assert property (
        (lclk_fall && lbu_run && !no_delay && valid_q[0] &&
         cnt_q[0] + 6'h01 < limit) |=> valid_q[0])
        else $error("request dropped early");
    a_restart_cnt: assert property (
        (lclk_fall && lbu_run && req_raw[1]) |=> valid_q[1] && cnt_q[1] == 6'h00)
        else $error("count not restarted");
    a_limit_map: assert property (
        dv_sel == DV_16 |-> limit == 6'h10)
        else $error("bad limit");
    a_tx_size: assert property (
        tiql_q[7:0] == 8'hff |-> txq_dwords_out == 13'd4096)
        else $error("tx size");
    a_rx_size: assert property (
        riql_q[7:0] == 8'h00 |-> rxq_dwords_out == 13'd16)
        else $error("rx size");
    a_pass_route: assert property (
        queue_irq_out |-> !data_mode_state_machine_irq_out && ipass)
        else $error("pass routing");
    a_base_align: assert property (
        txq_base_out[1:0] == 2'h0 && rxq_base_out[1:0] == 2'h0 &&
        host_rd_addr_out[1:0] == 2'h0)
        else $error("unaligned base");
    a_fetch_load: assert property (
        (fetch_busy_q && host_rvalid_in) |=> ccb_base_out == $past(host_rdata_in)
        && !host_rd_req_out)
        else $error("fetch not loaded");
    a_pin_b_pol: assert property (
        conf_q[CONF_SPINPINS] |-> chan_irq_out[1] ==
        (peripheral_irq_in_b_in ^ decode_alt_out))
        else $error("pin b polarity");
    a_shared_pin: assert property (
        !conf_q[CONF_SPINPINS] |-> chan_irq_out == {2{peripheral_irq_in_a_in}})
        else $error("shared pin routing");
endmodule : lbd_top

// file: bench/lbd_partner.sv
// model of the local bus peripheral clock and the host memory
`timescale 1ns/1ps
module lbd_partner (
    input  wire logic        clk_in,
    input  wire logic        host_rd_req_in,
    input  wire logic [31:0] host_rd_addr_in,
    output logic             lclk_out,
    output logic [31:0]      host_rdata_out,
    output logic             host_rvalid_out,
    output logic [7:0]       falls_out
);
    logic [1:0] div_q  = 2'h0;
    logic [1:0] wait_q = 2'h0;
    logic       lclk_q = 1'b1;
    logic [7:0] fall_q = 8'h00;
    logic       rv_q   = 1'b0;
    // out clock runs free at an eighth of the system rate
    always @(posedge clk_in) begin
        div_q <= div_q + 2'h1;
        if (div_q == 2'h3) lclk_q <= !lclk_q;
        if (div_q == 2'h3 && lclk_q) fall_q <= fall_q + 8'h01;
        wait_q <= (host_rd_req_in && !rv_q) ? wait_q + 2'h1 : 2'h0;
        rv_q <= (wait_q == 2'h2);
    end
    // data off the pulse is not the answer, so stale reads show up
    assign host_rdata_out  = rv_q ? ~host_rd_addr_in : host_rd_addr_in;
    assign host_rvalid_out = rv_q;
    assign lclk_out        = lclk_q;
    assign falls_out       = fall_q;
endmodule : lbd_partner

// file: bench/lbd_top_bench.sv
// self-checking bench for the local bus dma configuration block
`timescale 1ns/1ps
module lbd_top_bench;
    import lbd_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0;
    logic        bq = 1'b0, arv = 1'b0, rq = 1'b0, fst = 1'b0;
    logic [7:0]  awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0;
    logic [1:0]  req = 2'h0, pirq = 2'h0, src = 2'h0;
    logic        awr, wr_r, bv, arr, rv, lclk, hrq, hrv, dalt, dirq;
    logic        qirq, ebr, lbr, irq;
    logic [1:0]  bresp, rresp, dvo, eop, chi;
    logic [31:0] rd, hra, hrd, ccb, txb, rxb;
    logic [12:0] txn, rxn;
    logic [63:0] pra;
    logic [7:0]  falls;
    int          mismatches = 0;
    int          checks = 0;
    always #12.5 clk = !clk;
    lbd_partner i_lbd_partner (.clk_in(clk), .host_rd_req_in(hrq),
        .host_rd_addr_in(hra), .lclk_out(lclk), .host_rdata_out(hrd),
        .host_rvalid_out(hrv), .falls_out(falls));
    lbd_top i_lbd_top (
        .clk_sys_in(clk), .srst_in(rst), .s_awaddr_in(awa),
        .s_awvalid_in(awv), .s_awready_out(awr), .s_wdata_in(wd),
        .s_wstrb_in(4'hf), .s_wvalid_in(wv), .s_wready_out(wr_r),
        .s_bresp_out(bresp), .s_bvalid_out(bv), .s_bready_in(bq),
        .s_araddr_in(ara), .s_arvalid_in(arv), .s_arready_out(arr),
        .s_rdata_out(rd), .s_rresp_out(rresp), .s_rvalid_out(rv),
        .s_rready_in(rq), .local_bus_out_clock_in(lclk),
        .dma_request_chan_a_in(req[0]), .dma_request_chan_b_in(req[1]),
        .peripheral_irq_in_a_in(pirq[1]),
        .peripheral_irq_in_b_in(pirq[0]), .irq_source_in(src),
        .host_rdata_in(hrd), .host_rvalid_in(hrv), .fetch_start_in(fst),
        .host_rd_req_out(hrq), .host_rd_addr_out(hra),
        .ccb_base_out(ccb), .txq_base_out(txb), .txq_dwords_out(txn),
        .rxq_base_out(rxb), .rxq_dwords_out(rxn),
        .periph_reg_addr_out(pra), .dma_req_valid_out(dvo),
        .eop_pulse_out(eop), .decode_alt_out(dalt), .chan_irq_out(chi),
        .data_mode_state_machine_irq_out(dirq), .queue_irq_out(qirq),
        .ext_bus_ctrl_reset_n_out(ebr),
        .local_bus_unit_reset_n_out(lbr), .irq_out(irq));
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic axw(input logic [7:0] a, input logic [31:0] d,
                       input logic [1:0] er);
        logic       ha, hw, hb;
        logic [1:0] r;
        // one edge between transfers, so no strobe is driven twice in a step
        @(posedge clk);
        hb = 1'b0;
        {awa, wd, awv, wv, bq} <= {a, d, 3'b111};
        while (!hb) begin
            @(negedge clk);
            {ha, hw, hb, r} = {awv & awr, wv & wr_r, bv, bresp};
            @(posedge clk);
            {awv, wv, bq} <= {awv & !ha, wv & !hw, !hb};
        end
        chk(r, er);
    endtask : axw
    task automatic axr(input logic [7:0] a, input logic [31:0] ed,
                       input logic [1:0] er);
        logic ha, hr;
        @(posedge clk);
        hr = 1'b0;
        {ara, arv, rq} <= {a, 2'b11};
        while (!hr) begin
            @(negedge clk);
            {ha, hr} = {arv & arr, rv};
            if (hr) chk({rd, rresp}, {ed, er});
            @(posedge clk);
            {arv, rq} <= {arv & !ha, !hr};
        end
    endtask : axr
    task automatic t_regs;
        chk({ebr, lbr}, 2'b00);
        axr(OFF_CCBA, RST_ZERO, 2'h0);
        axr(OFF_TRAN, RST_TRAN, 2'h0);
        for (int i = 0; i < 6; i++) axr(8'h50 + 8'(4 * i), RST_ZERO, 2'h0);
        axw(OFF_TIQBA, 32'h1234_5677, 2'h0);
        axw(OFF_RIQBA, 32'h89ab_cdef, 2'h0);
        axw(OFF_TIQL, 32'h0000_01ff, 2'h0);
        axw(OFF_RIQL, 32'h0000_0005, 2'h0);
        axw(OFF_PTR0, 32'h0000_2020, 2'h0);
        axw(OFF_PTR1, 32'h383a_3b2a, 2'h0);
        axr(OFF_TIQBA, 32'h1234_5674, 2'h0);
        axr(OFF_TIQL, 32'h0000_00ff, 2'h0);
        chk({txb, rxb}, 64'h1234_5674_89ab_cdec);
        chk({txn, rxn}, {13'h1000, 13'h0060});
        chk(pra, 64'h383a_3b2a_0000_2020);
        axr(8'h30, 32'h0, 2'h2);
        $display("test regs done");
    endtask : t_regs
    task automatic t_fetch;
        axw(OFF_CONF, 32'h0000_0001, 2'h0);
        chk({ebr, lbr, dalt}, 3'b001);
        axw(OFF_CONF, 32'h0000_0301, 2'h0);
        chk({ebr, lbr}, 2'b11);
        axw(OFF_CCBA, 32'hcafe_0013, 2'h0);
        axr(OFF_CCBA, 32'hcafe_0010, 2'h0);
        fst <= 1'b1;
        @(posedge clk);
        fst <= 1'b0;
        @(negedge clk);
        chk(hrq, 1'b1);
        for (int i = 0; i < 30 && ccb !== 32'h3501_ffef; i++) @(posedge clk);
        chk({ccb, hra}, 64'h3501_ffef_cafe_0010);
        chk(hrq, 1'b0);
        $display("test fetch done");
    endtask : t_fetch
    task automatic set_conf(input logic [7:0] c);
        axw(OFF_CONF, {24'h0, c}, 2'h0);
        axw(OFF_CONF, {22'h0, 2'b11, c}, 2'h0);
    endtask : set_conf
    task automatic t_pins(input logic [2:0] c, input logic [1:0] ab,
                          input logic [1:0] s, input logic [3:0] e);
        set_conf({5'h0, c});
        {pirq, src} <= {ab, s};
        @(negedge clk);
        chk({chi, dirq, qirq}, e);
        @(posedge clk);
        $display("test pins %b done", c);
    endtask : t_pins
    task automatic t_dv(input logic [2:0] dv, input logic [7:0] n,
                        input logic rs);
        logic [7:0] f0;
        set_conf({1'b0, dv, 4'h0});
        axw(OFF_IRQ_STAT, 32'h0000_000f, 2'h0);
        req <= 2'b11;
        for (int k = 0; k <= int'(rs); k++) begin
            repeat (12) @(posedge clk);
            chk(dvo, 2'b11);
            while (lclk !== 1'b0) @(negedge clk);
            while (lclk !== 1'b1) @(negedge clk);
            f0 = falls;
            @(posedge clk);
            req <= 2'b00;
            // second pass only after a request returns in mid count
            while (rs && k == 0 && 8'(falls - f0) < 8'h03) @(posedge clk);
            if (rs && k == 0) req <= 2'b11;
        end
        for (int i = 0; i < 400 && dvo !== 2'b00; i++) @(negedge clk);
        chk(eop, 2'b11);
        chk(8'(falls - f0), n);
        axr(OFF_IRQ_STAT, {28'h0, dv == DV_RSVD, 3'b011}, 2'h0);
        chk(irq, 1'b0);
        axw(OFF_IRQ_MASK, 32'h0000_0001, 2'h0);
        chk(irq, 1'b1);
        axw(OFF_IRQ_STAT, 32'h0000_0001, 2'h0);
        chk(irq, 1'b0);
        axw(OFF_IRQ_MASK, 32'h0000_0000, 2'h0);
        $display("test validate %0d done", dv);
    endtask : t_dv
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : final_report
    initial begin
        #(25 * 20000);
        mismatches++;
        final_report();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_fetch();
        t_pins(3'b000, 2'b10, 2'h0, 4'b1110);
        t_pins(3'b000, 2'b01, 2'h0, 4'b0000);
        t_pins(3'b010, 2'b01, 2'h0, 4'b1010);
        t_pins(3'b011, 2'b00, 2'h0, 4'b1010);
        t_pins(3'b100, 2'b10, SRC_FRAMER3, 4'b1101);
        t_pins(3'b100, 2'b10, SRC_FRAMER4, 4'b1101);
        t_pins(3'b100, 2'b10, 2'h0, 4'b1110);
        t_dv(DV_NONE, 8'd1, 1'b0);
        t_dv(DV_RSVD, 8'd1, 1'b0);
        t_dv(DV_8, 8'd8, 1'b1);
        t_dv(DV_16, 8'd16, 1'b0);
        t_dv(DV_32, 8'd32, 1'b0);
        final_report();
    end
endmodule : lbd_top_bench
